// [sbcsc_checker.sv]
/*
 * per-bank command legality and state tracking for a four-bank double-rate
 * sdram command bus. decodes each command at the rising edge, moves the
 * bank states, times the automatic returns and flags illegal commands.
 * assumes the command pins come from another clock domain and are
 * synchronised here; no software registers, no interrupt.
 */
`timescale 1ns/100ps

// Overview of operation
// [R01] idle nop keeps idle or power-down
// [R02] idle read or write is illegal
// [R03] idle activate starts row activation
// [R04] precharge closes bank, or all banks
// [R05] idle refresh: auto, or self with cke low
// [R06] mode set writes selected register with opcode
// [R07] active read/write starts burst, autoprecharge optional
// [R08] active activate, refresh, mode set illegal
// [R09] nop during burst lets it finish
// [R10] read burst: only read interrupts
// [R11] write burst: only write interrupts
// [R12] autoprecharge burst: only nop legal
// [R13] precharging returns idle after trp
// [R14] precharge while precharging acts as nop
// [R15] activating becomes active after trcd
// [R16] write recovery returns active after twr
// [R17] write during recovery starts new burst
// [R18] recovery with autoprecharge then precharges
// [R19] refreshing returns idle after trc
// [R20] mode access returns idle after tmrd
// [R21] command decoded from strobes at edge
// [R22] other banks judged by own state
// [R23] refresh and mode set need all idle
// [R24] only length-eight bursts interrupted, boundary four
// [R25] illegal commands are flagged
module sbcsc_checker
(
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // command bus pins
    input wire logic cke_in,
    input wire logic cs_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic [sbcsc_pkg::BANK_BITS-1:0] bank_addr_in,
    input wire logic [sbcsc_pkg::ADDR_BITS-1:0] addr_in,
    // status
    output logic [4*sbcsc_pkg::NUM_BANKS-1:0] bank_state_out,
    output logic illegal_command_out,
    output logic [2:0] mode_select_out,
    output logic [sbcsc_pkg::ADDR_BITS-1:0] mode_opcode_out,
    output logic mode_write_out
);
    import sbcsc_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int PIN_BITS = 5 + BANK_BITS + ADDR_BITS;
    logic [PIN_BITS-1:0] pin_meta;
    logic [PIN_BITS-1:0] pin_sync;
    logic cke_prev;

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            pin_meta <= '0;
            pin_sync <= {1'b0, 4'hf, {(BANK_BITS+ADDR_BITS){1'b0}}};
        end
        else
        begin
            pin_meta <= {cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in, bank_addr_in, addr_in};
            pin_sync <= pin_meta;
        end
    end

    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_BITS-1:0] bank;
    logic [ADDR_BITS-1:0] addr;
    assign {cke, cs_n, ras_n, cas_n, we_n, bank, addr} = pin_sync;

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            cke_prev <= 1'b0;
        end
        else
        begin
            cke_prev <= cke;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    function automatic sbcsc_cmd_e sbcsc_decode(input logic cs, input logic ras,
                                                input logic cas, input logic we);
        if (cs)
        begin
            return SBCSC_CMD_DESELECT;
        end
        case ({ras, cas, we})
            3'h7: return SBCSC_CMD_NOP;
            3'h5: return SBCSC_CMD_READ;
            3'h4: return SBCSC_CMD_WRITE;
            3'h3: return SBCSC_CMD_ACTIVATE;
            3'h2: return SBCSC_CMD_PRECHARGE;
            3'h1: return SBCSC_CMD_REFRESH;
            3'h0: return SBCSC_CMD_MODE_SET;
            default: return SBCSC_CMD_NOP;
        endcase
    endfunction : sbcsc_decode

    sbcsc_cmd_e cmd;
    logic is_nop;
    logic auto_pre;
    assign cmd = sbcsc_decode(cs_n, ras_n, cas_n, we_n); // R21
    assign is_nop = (cmd == SBCSC_CMD_DESELECT) || (cmd == SBCSC_CMD_NOP);
    assign auto_pre = addr[AUTO_PRE_BIT];

    // ------------------------------------------------------------
    // burst length from the mode register and burst position
    // ------------------------------------------------------------
    logic [BURST_LEN_BITS-1:0] burst_len;

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            burst_len <= BURST_LEN_FOUR;
        end
        else if (cmd == SBCSC_CMD_MODE_SET && bank == '0 && cke)
        begin
            burst_len <= (addr[MODE_BL_LSB +: 3] == MODE_BL_CODE_EIGHT) ?
                         BURST_LEN_EIGHT : BURST_LEN_FOUR;
        end
    end

    // ------------------------------------------------------------
    // per-bank state machines
    // ------------------------------------------------------------
    sbcsc_state_e state [NUM_BANKS];
    logic [CNT_BITS-1:0] timer [NUM_BANKS];
    logic [NUM_BANKS-1:0] bank_illegal;
    logic all_idle;

    always_comb
    begin
        all_idle = 1'b1;
        for (int i = 0; i < NUM_BANKS; i++)
        begin
            if (state[i] != SBCSC_ST_IDLE)
            begin
                all_idle = 1'b0;
            end
        end
    end

    localparam logic [CNT_BITS-1:0] BURST_HALF_FOUR = CNT_BITS'(BURST_LEN_FOUR >> BURST_SHIFT);
    localparam logic [CNT_BITS-1:0] BURST_HALF_EIGHT = CNT_BITS'(BURST_LEN_EIGHT >> BURST_SHIFT);

    genvar g;
    generate
        for (g = 0; g < NUM_BANKS; g++)
        begin : g_bank
            logic sel;
            logic timed_out;
            logic [CNT_BITS-1:0] burst_cyc;
            logic on_boundary;
            sbcsc_state_e next_state;
            logic [CNT_BITS-1:0] next_timer;
            logic next_illegal;

            assign sel = (bank == BANK_BITS'(g)); // R22
            assign timed_out = (timer[g] <= CNT_BITS'(1));
            assign burst_cyc = (burst_len == BURST_LEN_EIGHT) ? BURST_HALF_EIGHT : BURST_HALF_FOUR;
            // an eight burst may be cut only after its first four beats
            assign on_boundary = (burst_len == BURST_LEN_EIGHT) && (timer[g] == BURST_HALF_FOUR); // R24

            always_comb
            begin
                next_state = state[g];
                next_timer = (timer[g] != '0) ? timer[g] - CNT_BITS'(1) : '0;
                next_illegal = 1'b0;
                case (state[g])
                    SBCSC_ST_IDLE:
                    begin
                        if (is_nop)
                        begin
                            if (!cke && cke_prev && all_idle)
                            begin
                                next_state = SBCSC_ST_POWER_DOWN; // R01
                            end
                        end
                        else if (cmd == SBCSC_CMD_REFRESH)
                        begin
                            next_timer = TRC_CYC;
                            next_state = cke ? SBCSC_ST_REFRESHING : SBCSC_ST_SELF_REFRESH; // R05
                            next_illegal = !all_idle; // R23
                        end
                        else if (cmd == SBCSC_CMD_MODE_SET)
                        begin
                            next_timer = TMRD_CYC;
                            next_state = SBCSC_ST_MODE_ACCESS; // R06
                            next_illegal = !all_idle; // R23
                        end
                        else if (cmd == SBCSC_CMD_PRECHARGE && (sel || auto_pre))
                        begin
                            next_timer = TRP_CYC;
                            next_state = SBCSC_ST_PRECHARGING; // R04
                        end
                        else if (sel && cmd == SBCSC_CMD_ACTIVATE)
                        begin
                            next_timer = TRCD_CYC;
                            next_state = SBCSC_ST_ACTIVATING; // R03
                        end
                        else if (sel && (cmd == SBCSC_CMD_READ || cmd == SBCSC_CMD_WRITE))
                        begin
                            next_illegal = 1'b1; // R02
                        end
                    end
                    SBCSC_ST_ACTIVATING:
                    begin
                        if (!is_nop && (sel || cmd == SBCSC_CMD_REFRESH || cmd == SBCSC_CMD_MODE_SET
                            || (cmd == SBCSC_CMD_PRECHARGE && auto_pre)))
                        begin
                            next_illegal = 1'b1; // R15
                        end
                        if (timed_out)
                        begin
                            next_state = SBCSC_ST_ACTIVE; // R15
                        end
                    end
                    SBCSC_ST_ACTIVE:
                    begin
                        if (cmd == SBCSC_CMD_REFRESH || cmd == SBCSC_CMD_MODE_SET)
                        begin
                            next_illegal = 1'b1; // R08
                        end
                        else if (cmd == SBCSC_CMD_PRECHARGE && (sel || auto_pre))
                        begin
                            next_timer = TRP_CYC;
                            next_state = SBCSC_ST_PRECHARGING; // R04
                        end
                        else if (sel && cmd == SBCSC_CMD_ACTIVATE)
                        begin
                            next_illegal = 1'b1; // R08
                        end
                        else if (sel && (cmd == SBCSC_CMD_READ || cmd == SBCSC_CMD_WRITE))
                        begin
                            next_timer = burst_cyc;
                            if (cmd == SBCSC_CMD_READ)
                            begin
                                next_state = auto_pre ? SBCSC_ST_READ_AP : SBCSC_ST_READ; // R07
                            end
                            else
                            begin
                                next_state = auto_pre ? SBCSC_ST_WRITE_AP : SBCSC_ST_WRITE; // R07
                            end
                        end
                        else if (!cke && cke_prev && is_nop)
                        begin
                            next_state = SBCSC_ST_POWER_DOWN;
                        end
                    end
                    SBCSC_ST_READ, SBCSC_ST_WRITE:
                    begin
                        if (sel && ((state[g] == SBCSC_ST_READ && cmd == SBCSC_CMD_READ)
                            || (state[g] == SBCSC_ST_WRITE && cmd == SBCSC_CMD_WRITE)))
                        begin
                            next_timer = burst_cyc;
                            next_illegal = !on_boundary; // R24
                            if (auto_pre)
                            begin
                                next_state = (cmd == SBCSC_CMD_READ) ? SBCSC_ST_READ_AP
                                                                     : SBCSC_ST_WRITE_AP;
                            end
                        end
                        else if (!is_nop && (sel || cmd == SBCSC_CMD_REFRESH
                                 || cmd == SBCSC_CMD_MODE_SET
                                 || (cmd == SBCSC_CMD_PRECHARGE && auto_pre)))
                        begin
                            next_illegal = 1'b1; // R10 R11
                        end
                        else if (timed_out)
                        begin
                            next_timer = TWR_CYC;
                            next_state = (state[g] == SBCSC_ST_READ) ? SBCSC_ST_ACTIVE
                                                                     : SBCSC_ST_WRITE_RECOVER; // R09
                        end
                    end
                    SBCSC_ST_READ_AP, SBCSC_ST_WRITE_AP:
                    begin
                        if (!is_nop && (sel || cmd == SBCSC_CMD_REFRESH
                            || cmd == SBCSC_CMD_MODE_SET
                            || (cmd == SBCSC_CMD_PRECHARGE && auto_pre)))
                        begin
                            next_illegal = 1'b1; // R12
                        end
                        if (timed_out)
                        begin
                            next_timer = (state[g] == SBCSC_ST_READ_AP) ? TRP_CYC : TWR_CYC;
                            next_state = (state[g] == SBCSC_ST_READ_AP) ? SBCSC_ST_PRECHARGING
                                                                        : SBCSC_ST_WRITE_RECOVER_AP; // R09
                        end
                    end
                    SBCSC_ST_WRITE_RECOVER:
                    begin
                        if (sel && cmd == SBCSC_CMD_WRITE)
                        begin
                            next_timer = burst_cyc;
                            next_state = auto_pre ? SBCSC_ST_WRITE_AP : SBCSC_ST_WRITE; // R17
                        end
                        else if (!is_nop && (sel || cmd == SBCSC_CMD_REFRESH
                                 || cmd == SBCSC_CMD_MODE_SET
                                 || (cmd == SBCSC_CMD_PRECHARGE && auto_pre)))
                        begin
                            next_illegal = 1'b1; // R16
                        end
                        else if (timed_out)
                        begin
                            next_state = SBCSC_ST_ACTIVE; // R16
                        end
                    end
                    SBCSC_ST_WRITE_RECOVER_AP:
                    begin
                        if (!is_nop && (sel || cmd == SBCSC_CMD_REFRESH
                            || cmd == SBCSC_CMD_MODE_SET
                            || (cmd == SBCSC_CMD_PRECHARGE && auto_pre)))
                        begin
                            next_illegal = 1'b1; // R18
                        end
                        if (timed_out)
                        begin
                            next_timer = TRP_CYC;
                            next_state = SBCSC_ST_PRECHARGING; // R18
                        end
                    end
                    SBCSC_ST_PRECHARGING:
                    begin
                        // a repeated precharge neither restarts nor fails
                        if (!is_nop && cmd != SBCSC_CMD_PRECHARGE
                            && (sel || cmd == SBCSC_CMD_REFRESH || cmd == SBCSC_CMD_MODE_SET))
                        begin
                            next_illegal = 1'b1; // R13
                        end
                        if (timed_out)
                        begin
                            next_state = SBCSC_ST_IDLE; // R13 R14
                        end
                    end
                    SBCSC_ST_REFRESHING, SBCSC_ST_MODE_ACCESS:
                    begin
                        // every bank is busy here, so any real command is illegal
                        next_illegal = !is_nop; // R19 R20
                        if (timed_out)
                        begin
                            next_state = SBCSC_ST_IDLE; // R19 R20
                        end
                    end
                    SBCSC_ST_POWER_DOWN, SBCSC_ST_SELF_REFRESH:
                    begin
                        if (cke && !cke_prev)
                        begin
                            next_state = SBCSC_ST_IDLE;
                            next_illegal = !is_nop;
                        end
                    end
                    default:
                    begin
                        next_state = SBCSC_ST_IDLE;
                    end
                endcase
            end

            always_ff @(posedge clock_in or posedge sys_rst_in)
            begin
                if (sys_rst_in)
                begin
                    state[g] <= SBCSC_ST_IDLE;
                    timer[g] <= '0;
                    bank_illegal[g] <= 1'b0;
                end
                else
                begin
                    state[g] <= next_state;
                    timer[g] <= next_timer;
                    bank_illegal[g] <= next_illegal;
                end
            end

            assign bank_state_out[4*g +: 4] = state[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            illegal_command_out <= 1'b0;
            mode_select_out <= '0;
            mode_opcode_out <= '0;
            mode_write_out <= 1'b0;
        end
        else
        begin
            illegal_command_out <= |(bank_illegal); // R25
            mode_write_out <= (cmd == SBCSC_CMD_MODE_SET) && all_idle && cke; // R06
            if (cmd == SBCSC_CMD_MODE_SET && all_idle && cke)
            begin
                mode_select_out <= {1'b0, bank}; // R06
                mode_opcode_out <= addr;
            end
        end
    end

endmodule : sbcsc_checker

// [sbcsc_pkg.sv]
/*
 * package for the sdram bank command state checker: command codes, bank
 * states, timing figures and the cycle counts derived from them.
 * assumes a 20 MHz core clock and a four-bank part with a 13-bit address bus.
 */
package sbcsc_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NUM_BANKS = 4;
    localparam int BANK_BITS = 2;
    localparam int ADDR_BITS = 13;
    localparam int AUTO_PRE_BIT = 10;
    localparam int BURST_LEN_BITS = 4;
    localparam logic [3:0] BURST_LEN_FOUR = 4'h4;
    localparam logic [3:0] BURST_LEN_EIGHT = 4'h8;
    localparam int MODE_BL_LSB = 0;
    localparam logic [2:0] MODE_BL_CODE_FOUR = 3'h2;
    localparam logic [2:0] MODE_BL_CODE_EIGHT = 3'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int TRP_NS = 15;
    localparam int TRCD_NS = 15;
    localparam int TWR_NS = 15;
    localparam int TRC_NS = 60;
    localparam int TMRD_CK = 2;
    localparam int CNT_BITS = 4;

    // least times round up, never below one cycle
    function automatic logic [CNT_BITS-1:0] sbcsc_cycles(input int ns);
        int c;
        c = (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
        if (c < 1)
        begin
            c = 1;
        end
        return CNT_BITS'(c);
    endfunction : sbcsc_cycles

    localparam logic [CNT_BITS-1:0] TRP_CYC = sbcsc_cycles(TRP_NS);
    localparam logic [CNT_BITS-1:0] TRCD_CYC = sbcsc_cycles(TRCD_NS);
    localparam logic [CNT_BITS-1:0] TWR_CYC = sbcsc_cycles(TWR_NS);
    localparam logic [CNT_BITS-1:0] TRC_CYC = sbcsc_cycles(TRC_NS);
    localparam logic [CNT_BITS-1:0] TMRD_CYC = CNT_BITS'(TMRD_CK);
    // data occupies burst_len/2 clocks on a double-rate bus
    localparam int BURST_SHIFT = 1;

    // ------------------------------------------------------------
    // decoded commands and bank states
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        SBCSC_CMD_DESELECT,
        SBCSC_CMD_NOP,
        SBCSC_CMD_READ,
        SBCSC_CMD_WRITE,
        SBCSC_CMD_ACTIVATE,
        SBCSC_CMD_PRECHARGE,
        SBCSC_CMD_REFRESH,
        SBCSC_CMD_MODE_SET
    } sbcsc_cmd_e;

    typedef enum logic [3:0]
    {
        SBCSC_ST_IDLE,
        SBCSC_ST_ACTIVATING,
        SBCSC_ST_ACTIVE,
        SBCSC_ST_READ,
        SBCSC_ST_READ_AP,
        SBCSC_ST_WRITE,
        SBCSC_ST_WRITE_AP,
        SBCSC_ST_WRITE_RECOVER,
        SBCSC_ST_WRITE_RECOVER_AP,
        SBCSC_ST_PRECHARGING,
        SBCSC_ST_REFRESHING,
        SBCSC_ST_MODE_ACCESS,
        SBCSC_ST_POWER_DOWN,
        SBCSC_ST_SELF_REFRESH
    } sbcsc_state_e;

endpackage : sbcsc_pkg

// [sbcsc_checker_asserts.sv]
/* bank state assertions on the top ports of sbcsc_checker.
   assumes the three-edge latency from pins to bank state. */
`timescale 1ns/100ps
module sbcsc_checker_asserts
(
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // command pins
    input wire logic cs_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic [sbcsc_pkg::BANK_BITS-1:0] bank_addr_in,
    // status
    input wire logic [4*sbcsc_pkg::NUM_BANKS-1:0] bank_state_out,
    input wire logic illegal_command_out,
    input wire logic mode_write_out
);
    import sbcsc_pkg::*;
    wire [3:0] st0;
    wire [3:0] cmd;
    assign st0 = bank_state_out[3:0];
    assign cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
    // --------
    // properties
    // --------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);
    sequence to_b0(logic [3:0] c);
        cmd == c && bank_addr_in == 2'h0;
    endsequence
    sequence held_idle;
        (bank_state_out == '0) [*3];
    endsequence
    a_idle_read_flag: assert property
        (to_b0(4'h5) ##0 held_idle |-> ##[1:3] illegal_command_out) else $error("idle read");
    a_act_starts_row: assert property
        (to_b0(4'h3) ##0 held_idle |-> ##[1:4] st0 == SBCSC_ST_ACTIVATING) else $error("act");
    a_mode_set_taken: assert property
        ((cmd == 4'h0) ##0 held_idle |-> ##[1:3] mode_write_out) else $error("mode set");
    a_mode_pulse_once: assert property
        (mode_write_out |=> !mode_write_out) else $error("mode pulse");
    a_activating_ends: assert property
        (st0 == SBCSC_ST_ACTIVATING |-> ##[1:2] st0 == SBCSC_ST_ACTIVE) else $error("trcd");
    a_precharge_ends: assert property
        (st0 == SBCSC_ST_PRECHARGING |-> ##[1:2] st0 == SBCSC_ST_IDLE) else $error("trp");
    a_refresh_ends: assert property
        (st0 == SBCSC_ST_REFRESHING |-> ##[1:3] st0 == SBCSC_ST_IDLE) else $error("trc");
    a_mode_access_ends: assert property
        (st0 == SBCSC_ST_MODE_ACCESS |-> ##[1:3] st0 == SBCSC_ST_IDLE) else $error("tmrd");
    a_recover_ends: assert property
        (st0 == SBCSC_ST_WRITE_RECOVER |-> ##[1:2]
         st0 inside {SBCSC_ST_ACTIVE, SBCSC_ST_WRITE, SBCSC_ST_WRITE_AP}) else $error("twr");
    a_autopre_closes: assert property
        (st0 == SBCSC_ST_READ_AP |-> ##[1:5] st0 == SBCSC_ST_PRECHARGING) else $error("ap");
endmodule : sbcsc_checker_asserts
bind sbcsc_checker sbcsc_checker_asserts u_chk (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
    .cs_n_in(cs_n_in), .ras_n_in(ras_n_in), .cas_n_in(cas_n_in), .we_n_in(we_n_in),
    .bank_addr_in(bank_addr_in), .bank_state_out(bank_state_out),
    .illegal_command_out(illegal_command_out), .mode_write_out(mode_write_out));

// [sbcsc_ctrl_model.sv]
/* controller model driving the command pins, one command per clock.
   assumes the bench calls issue once per clock edge. */
`timescale 1ns/100ps
module sbcsc_ctrl_model
(
    // clock
    input wire logic clock_in,
    // command pins
    output logic cke_out,
    output logic [3:0] pins_out,
    output logic [1:0] bank_out,
    output logic [12:0] addr_out
);
    initial
    begin
        cke_out = 1'b1;
        pins_out = 4'hf;
        bank_out = 2'h0;
        addr_out = 13'h0;
    end
    // pins change just after the edge and hold one whole cycle
    task automatic issue(input logic [3:0] p, input logic [1:0] b, input logic [12:0] a);
        @(posedge clock_in);
        #1;
        if (p[3])
        begin
            // deselected lines show no stale value
            pins_out = {1'b1, ~pins_out[2:0]};
            bank_out = ~bank_out;
            addr_out = ~addr_out;
        end
        else
        begin
            pins_out = p;
            bank_out = b;
            addr_out = a;
        end
    endtask : issue
    task automatic set_cke(input logic v, input logic [3:0] p);
        issue(p, 2'h0, 13'h0);
        cke_out = v;
    endtask : set_cke
endmodule : sbcsc_ctrl_model

// [tb_sdram_bank_command_state_checker.sv]
/* self-checking bench for sbcsc_checker.
   assumes the controller model in sbcsc_ctrl_model. */
`timescale 1ns/100ps
module tb_sdram_bank_command_state_checker;
    import sbcsc_pkg::*;
    typedef struct packed
    {
        logic [3:0] p;
        logic [12:0] a;
        logic [15:0] st;
        logic ill;
    } sbcsc_row_s;
    sbcsc_row_s rows [10] = '{
        '{4'h5, 13'h0, 16'h0, 1'b1}, '{4'h3, 13'h0, 16'h2, 1'b0},
        '{4'h0, 13'h0, 16'h2, 1'b1}, '{4'h2, 13'h0, 16'h0, 1'b0},
        '{4'h1, 13'h0, 16'h0, 1'b0}, '{4'h0, 13'h3, 16'h0, 1'b0},
        '{4'h3, 13'h0, 16'h2, 1'b0}, '{4'h5, 13'h0, 16'h2, 1'b0},
        '{4'h4, 13'h0, 16'h2, 1'b0}, '{4'h4, 13'h400, 16'h0, 1'b0}};
    logic clock_in;
    logic sys_rst_in;
    wire cke;
    wire ill;
    wire mw;
    wire [3:0] pins;
    wire [1:0] ba;
    wire [12:0] addr;
    wire [15:0] st;
    wire [2:0] msel;
    wire [12:0] mop;
    int err_count;
    int comparisons;
    int ill_n;
    int k;
    sbcsc_ctrl_model ctl (.clock_in(clock_in), .cke_out(cke), .pins_out(pins), .bank_out(ba),
        .addr_out(addr));
    sbcsc_checker uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .cke_in(cke),
        .cs_n_in(pins[3]), .ras_n_in(pins[2]), .cas_n_in(pins[1]), .we_n_in(pins[0]),
        .bank_addr_in(ba), .addr_in(addr), .bank_state_out(st), .illegal_command_out(ill),
        .mode_select_out(msel), .mode_opcode_out(mop), .mode_write_out(mw));
    initial
    begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    always @(posedge clock_in)
    begin
        ill_n += (ill === 1'b1);
    end
    task automatic end_sim;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // deselect, then wait for the bank states to reach exp
    task automatic settle(input logic [15:0] exp);
        int n;
        n = 0;
        ctl.issue(4'h8, 2'h0, 13'h0);
        repeat (4) @(posedge clock_in);
        while (st !== exp && n < 20)
        begin
            @(posedge clock_in);
            n++;
        end
        if (n == 20)
        begin
            err_count++;
            end_sim();
        end
        repeat (3) @(posedge clock_in);
        chk(st, exp);
    endtask : settle
    task automatic op(input logic [3:0] p, input logic [1:0] b, input logic [12:0] a);
        ctl.issue(p, b, a);
    endtask : op
    initial
    begin
        sys_rst_in = 1'b1;
        err_count = 0;
        comparisons = 0;
        ill_n = 0;
        repeat (3) @(posedge clock_in);
        #1 sys_rst_in = 1'b0;
        foreach (rows[i])
        begin
            k = ill_n;
            op(rows[i].p, 2'h0, rows[i].a);
            settle(rows[i].st);
            chk(16'(ill_n - k), 16'(rows[i].ill));
        end
        chk({msel, mop}, 16'h3);
        op(4'h3, 2'h0, 13'h0);
        op(4'h3, 2'h1, 13'h0);
        settle(16'h22);
        k = ill_n;
        op(4'h1, 2'h0, 13'h0);
        op(4'h2, 2'h0, 13'h400);
        settle(16'h0);
        chk(16'(ill_n - k), 16'h2);
        op(4'h3, 2'h0, 13'h0);
        settle(16'h2);
        k = ill_n;
        op(4'h5, 2'h0, 13'h400);
        op(4'h8, 2'h0, 13'h0);
        op(4'h4, 2'h0, 13'h0);
        settle(16'h0);
        chk(16'(ill_n - k), 16'h1);
        op(4'h3, 2'h0, 13'h0);
        settle(16'h2);
        k = ill_n;
        op(4'h2, 2'h0, 13'h0);
        op(4'h2, 2'h0, 13'h0);
        settle(16'h0);
        chk(16'(ill_n - k), 16'h0);
        ctl.set_cke(1'b0, 4'h8);
        settle(16'hcccc);
        ctl.set_cke(1'b1, 4'h8);
        settle(16'h0);
        ctl.set_cke(1'b0, 4'h1);
        settle(16'hdddd);
        ctl.set_cke(1'b1, 4'h8);
        op(4'h3, 2'h2, 13'h0);
        repeat (5) @(posedge clock_in);
        #1 sys_rst_in = 1'b1;
        @(posedge clock_in);
        chk(st, 16'h0);
        chk({msel, mop}, 16'h0);
        #1 sys_rst_in = 1'b0;
        end_sim();
    end
endmodule : tb_sdram_bank_command_state_checker
